// ### src/sqx_defs.vh
`ifndef SQX_DEFS_VH
`define SQX_DEFS_VH

// sequencer opcodes
`define SQX_OP_SS_HIGH   8'h01
`define SQX_OP_SS_LOW    8'h80
`define SQX_OP_I2C_RDNAK 8'hD3
`define SQX_OP_SPI_BYTE  8'hC0
`define SQX_OP_SPI_BIT   8'hB0

`define SQX_FILL         8'hFF

// clock and serial rates in Hz
`define SQX_CLK_HZ       10000000
`define SQX_I2C_HZ       100000
`define SQX_SPI_BYTE_HZ  1000000
`define SQX_SPI_BIT_HZ   134000

// full periods round up so no rate exceeds its ceiling
`define SQX_PER(hz)      ((`SQX_CLK_HZ + (hz) - 1) / (hz))
`define SQX_HALF(hz)     ((`SQX_PER(hz) + 1) / 2)
`define SQX_I2C_HALF     `SQX_HALF(`SQX_I2C_HZ)
`define SQX_BYTE_HALF    `SQX_HALF(`SQX_SPI_BYTE_HZ)
`define SQX_BIT_HALF     `SQX_HALF(`SQX_SPI_BIT_HZ)

// write buffer: {address, byte}
`define SQX_AW           9
`define SQX_FIFO_W       17
`define SQX_FIFO_D       16
`define SQX_FIFO_AW      4

`endif

// ### src/sqx_fifo.v
`timescale 1ns/1ps
`default_nettype none

module sqx_fifo #(
  parameter W  = 17,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data,
  output wire         o_empty
);

  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign o_in_ready  = (cnt_q != D[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_empty     = ~o_out_valid;
  assign o_out_data  = mem_q[rp_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### src/sqx_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "sqx_defs.vh"

module sqx_exec (
  input  wire                i_clk,
  input  wire                i_arst_n,
  input  wire                i_cmd_start,
  input  wire [`SQX_AW-1:0]  i_cmd_addr,
  output reg                 o_busy,
  output reg                 o_cmd_done,
  output reg                 o_cmd_err,
  output reg  [`SQX_AW-1:0]  o_next_addr,
  output reg                 o_mem_rd,
  output reg  [`SQX_AW-1:0]  o_mem_raddr,
  input  wire [7:0]          i_mem_rdata,
  output reg                 o_mem_wr,
  output reg  [`SQX_AW-1:0]  o_mem_waddr,
  output reg  [7:0]          o_mem_wdata,
  input  wire                i_mem_wr_ready,
  input  wire                i_strong_pullup_active,
  input  wire                i_link_valid,
  output reg                 o_link_ready,
  output reg                 o_scl_o,
  output reg                 o_scl_oe,
  input  wire                i_scl,
  output reg                 o_sda_o,
  output reg                 o_sda_oe,
  input  wire                i_sda,
  output reg                 o_sck,
  output reg                 o_mosi,
  input  wire                i_miso,
  output reg                 o_ss_n
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RD    = 3'h1;
  localparam [2:0] S_RDW   = 3'h2;
  localparam [2:0] S_BIT   = 3'h3;
  localparam [2:0] S_STORE = 3'h4;
  localparam [2:0] S_ACK   = 3'h5;
  localparam [2:0] S_FIN   = 3'h6;

  localparam [1:0] F_OP  = 2'h0;
  localparam [1:0] F_LN1 = 2'h1;
  localparam [1:0] F_LN2 = 2'h2;
  localparam [1:0] F_WD  = 2'h3;

  localparam integer I2C_HALF_N  = `SQX_I2C_HALF - 1;
  localparam integer BYTE_HALF_N = `SQX_BYTE_HALF - 1;
  localparam integer BIT_HALF_N  = `SQX_BIT_HALF - 1;
  localparam [5:0]   I2C_HALF    = I2C_HALF_N[5:0];
  localparam [5:0]   BYTE_HALF   = BYTE_HALF_N[5:0];
  localparam [5:0]   BIT_HALF    = BIT_HALF_N[5:0];

  // length field to bit count; byte command counts eight bits per byte
  function [11:0] len_bits;
    input [7:0] op;
    input [7:0] len;
    begin
      if (op == `SQX_OP_SPI_BYTE) begin
        len_bits = {1'b0, len, 3'h0};
      end else begin
        len_bits = {4'h0, len};
      end
    end
  endfunction

  reg        rst_m_q;
  reg        rst_n_q;
  reg        spu_m_q;
  reg        spu_q;
  reg        sda_m_q;
  reg        sda_q;
  reg        scl_m_q;
  reg        scl_q;
  reg        miso_m_q;
  reg        miso_q;

  reg [2:0]  st_q;
  reg [1:0]  fld_q;
  reg [7:0]  op_q;
  reg [`SQX_AW-1:0] ptr_q;
  reg        i2c_q;
  reg        rdph_q;
  reg [11:0] rem_q;
  reg [11:0] rbits_q;
  reg [2:0]  bi_q;
  reg [7:0]  sh_q;
  reg        ph_q;
  reg [5:0]  div_q;
  reg        err_q;
  reg        push_q;
  reg [`SQX_FIFO_W-1:0] pdat_q;

  wire       ff_in_rdy;
  wire       ff_out_vld;
  wire       ff_empty;
  wire       ff_out_rdy;
  wire [`SQX_FIFO_W-1:0] ff_out;
  wire       serial;
  wire       tick;
  wire       last_bit;

  // pins cross in through two flops; the first stage feeds nothing else
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      spu_m_q  <= 1'b0;
      spu_q    <= 1'b0;
      sda_m_q  <= 1'b1;
      sda_q    <= 1'b1;
      scl_m_q  <= 1'b1;
      scl_q    <= 1'b1;
      miso_m_q <= 1'b1;
      miso_q   <= 1'b1;
    end else begin
      spu_m_q  <= i_strong_pullup_active;
      spu_q    <= spu_m_q;
      sda_m_q  <= i_sda;
      sda_q    <= sda_m_q;
      scl_m_q  <= i_scl;
      scl_q    <= scl_m_q;
      miso_m_q <= i_miso;
      miso_q   <= miso_m_q;
    end
  end

  assign serial = (st_q == S_BIT) | (st_q == S_ACK);
  // a slave holding SCL low stretches the high phase
  assign tick   = serial & (div_q == 6'h00) & ~(i2c_q & ph_q & ~scl_q);
  assign last_bit = i2c_q ? (bi_q == 3'h7) : ((bi_q == 3'h7) | (rem_q == 12'h001));

  // half-period divider, rate chosen by the running command; outside serial states it reloads the bit rate for both SPI commands
  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= 6'h00;
    end else if (!serial) begin
      div_q <= i2c_q ? I2C_HALF : BIT_HALF;
    end else if (div_q == 6'h00) begin
      if (tick) begin
        if (i2c_q) begin
          div_q <= I2C_HALF;
        end else if (op_q == `SQX_OP_SPI_BIT) begin
          div_q <= BIT_HALF;
        end else begin
          div_q <= BYTE_HALF;
        end
      end
    end else begin
      div_q <= div_q - 6'h01;
    end
  end

  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q        <= S_IDLE;
      fld_q       <= F_OP;
      op_q        <= 8'h00;
      ptr_q       <= {`SQX_AW{1'b0}};
      i2c_q       <= 1'b0;
      rdph_q      <= 1'b0;
      rem_q       <= 12'h000;
      rbits_q     <= 12'h000;
      bi_q        <= 3'h0;
      sh_q        <= `SQX_FILL;
      ph_q        <= 1'b0;
      err_q       <= 1'b0;
      push_q      <= 1'b0;
      pdat_q      <= {`SQX_FIFO_W{1'b0}};
      o_busy      <= 1'b0;
      o_cmd_done  <= 1'b0;
      o_cmd_err   <= 1'b0;
      o_next_addr <= {`SQX_AW{1'b0}};
      o_mem_rd    <= 1'b0;
      o_mem_raddr <= {`SQX_AW{1'b0}};
      o_link_ready <= 1'b0;
      o_scl_o     <= 1'b0;
      o_scl_oe    <= 1'b0;
      o_sda_o     <= 1'b0;
      o_sda_oe    <= 1'b0;
      o_sck       <= 1'b0;
      o_mosi      <= 1'b1;
      o_ss_n      <= 1'b1;
    end else begin
      o_mem_rd   <= 1'b0;
      o_cmd_done <= 1'b0;
      o_cmd_err  <= 1'b0;
      if (push_q & ff_in_rdy) begin
        push_q <= 1'b0;
      end
      o_busy       <= (st_q != S_IDLE) | i_cmd_start;
      o_link_ready <= (st_q == S_IDLE) & ~i_cmd_start;
      case (st_q)
        S_IDLE: begin
          if (i_cmd_start) begin
            ptr_q <= i_cmd_addr;
            fld_q <= F_OP;
            err_q <= 1'b0;
            st_q  <= S_RD;
          end
        end
        S_RD: begin
          o_mem_rd    <= 1'b1;
          o_mem_raddr <= ptr_q;
          ptr_q       <= ptr_q + 1'b1;
          st_q        <= S_RDW;
        end
        S_RDW: begin
          sh_q <= i_mem_rdata;
          bi_q <= 3'h0;
          ph_q <= 1'b0;
          case (fld_q)
            F_OP: begin
              op_q  <= i_mem_rdata;
              i2c_q <= (i_mem_rdata == `SQX_OP_I2C_RDNAK);
              fld_q <= F_LN1;
              st_q  <= S_RD;
              if (!spu_q) begin
                err_q <= 1'b1;
                st_q  <= S_FIN;
              end else if (i_mem_rdata == `SQX_OP_SS_HIGH) begin
                o_ss_n <= 1'b1;
                st_q   <= S_FIN;
              end else if (i_mem_rdata == `SQX_OP_SS_LOW) begin
                o_ss_n <= 1'b0;
                st_q   <= S_FIN;
              end else if ((i_mem_rdata != `SQX_OP_I2C_RDNAK) &&
                           (i_mem_rdata != `SQX_OP_SPI_BYTE) &&
                           (i_mem_rdata != `SQX_OP_SPI_BIT)) begin
                err_q <= 1'b1;
                st_q  <= S_FIN;
              end
            end
            F_LN1: begin
              if (i2c_q) begin
                rem_q  <= (i_mem_rdata == 8'h00) ? 12'h100 : {4'h0, i_mem_rdata};
                rdph_q <= 1'b1;
                sh_q   <= `SQX_FILL;
                st_q   <= S_BIT;
              end else begin
                rem_q <= len_bits(op_q, i_mem_rdata);
                fld_q <= F_LN2;
                st_q  <= S_RD;
              end
            end
            F_LN2: begin
              rbits_q <= len_bits(op_q, i_mem_rdata);
              sh_q    <= `SQX_FILL;
              if (rem_q != 12'h000) begin
                rdph_q <= 1'b0;
                fld_q  <= F_WD;
                st_q   <= S_RD;
              end else if (i_mem_rdata != 8'h00) begin
                rdph_q <= 1'b1;
                rem_q  <= len_bits(op_q, i_mem_rdata);
                st_q   <= S_BIT;
              end else begin
                st_q <= S_FIN;
              end
            end
            default: begin
              o_mosi <= i_mem_rdata[7];
              st_q   <= S_BIT;
            end
          endcase
        end
        S_BIT: begin
          if (!spu_q) begin
            err_q <= 1'b1;
            st_q  <= S_FIN;
          end else if (tick) begin
            ph_q <= ~ph_q;
            if (!ph_q) begin
              o_scl_oe <= 1'b0;
              o_sck    <= ~i2c_q;
              if (rdph_q) begin
                sh_q <= {sh_q[6:0], i2c_q ? sda_q : miso_q};
              end
            end else begin
              o_scl_oe <= i2c_q;
              o_sck    <= 1'b0;
              bi_q     <= bi_q + 3'h1;
              if (!i2c_q) begin
                rem_q <= rem_q - 12'h001;
              end
              if (!rdph_q) begin
                sh_q   <= {sh_q[6:0], 1'b1};
                o_mosi <= sh_q[6];
              end
              if (last_bit) begin
                if (rdph_q) begin
                  push_q <= 1'b1;
                  pdat_q <= {ptr_q, sh_q};
                  st_q   <= S_STORE;
                end else if (rem_q != 12'h001) begin
                  st_q <= S_RD;
                end else if (rbits_q != 12'h000) begin
                  rdph_q <= 1'b1;
                  rem_q  <= rbits_q;
                  sh_q   <= `SQX_FILL;
                  bi_q   <= 3'h0;
                  o_mosi <= 1'b1;
                end else begin
                  o_mosi <= 1'b1;
                  st_q   <= S_FIN;
                end
              end
            end
          end
        end
        S_STORE: begin
          // the byte waits here until the write buffer takes it
          if (push_q & ff_in_rdy) begin
            ptr_q <= ptr_q + 1'b1;
            sh_q  <= `SQX_FILL;
            bi_q  <= 3'h0;
            if (i2c_q) begin
              rem_q    <= rem_q - 12'h001;
              o_sda_oe <= (rem_q != 12'h001);
              st_q     <= S_ACK;
            end else if (rem_q == 12'h000) begin
              st_q <= S_FIN;
            end else begin
              st_q <= S_BIT;
            end
          end
        end
        S_ACK: begin
          if (tick) begin
            ph_q <= ~ph_q;
            if (!ph_q) begin
              o_scl_oe <= 1'b0;
            end else begin
              o_scl_oe <= 1'b1;
              o_sda_oe <= 1'b0;
              st_q     <= (rem_q == 12'h000) ? S_FIN : S_BIT;
            end
          end
        end
        S_FIN: begin
          // completion waits until every stored byte has reached memory
          o_sck  <= 1'b0;
          o_mosi <= 1'b1;
          if (ff_empty & ~push_q & ~o_mem_wr) begin
            o_cmd_done  <= ~err_q;
            o_cmd_err   <= err_q;
            o_next_addr <= ptr_q;
            o_scl_oe    <= 1'b0;
            o_sda_oe    <= 1'b0;
            st_q        <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // memory write stage: buffer drains whenever the port accepts
  assign ff_out_rdy = ~o_mem_wr | i_mem_wr_ready;

  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_mem_wr    <= 1'b0;
      o_mem_waddr <= {`SQX_AW{1'b0}};
      o_mem_wdata <= 8'h00;
    end else if (ff_out_rdy) begin
      o_mem_wr <= ff_out_vld;
      if (ff_out_vld) begin
        o_mem_waddr <= ff_out[16:8];
        o_mem_wdata <= ff_out[7:0];
      end
    end
  end

  sqx_fifo #(
    .W  (`SQX_FIFO_W),
    .D  (`SQX_FIFO_D),
    .AW (`SQX_FIFO_AW)
  ) u_wbuf (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n_q),
    .i_in_valid  (push_q),
    .o_in_ready  (ff_in_rdy),
    .i_in_data   (pdat_q),
    .o_out_valid (ff_out_vld),
    .i_out_ready (ff_out_rdy),
    .o_out_data  (ff_out),
    .o_empty     (ff_empty)
  );

  // link requests are never taken here; only readiness is reported
  wire unused_link = i_link_valid;

endmodule

`default_nettype wire

// ### tb/sqx_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sqx_exec_checker (
  input wire       i_clk,
  input wire       i_arst_n,
  input wire       i_cmd_start,
  input wire       o_busy,
  input wire       o_cmd_done,
  input wire       o_cmd_err,
  input wire       o_mem_rd,
  input wire [7:0] i_mem_rdata,
  input wire       o_mem_wr,
  input wire [8:0] o_mem_waddr,
  input wire [7:0] o_mem_wdata,
  input wire       i_mem_wr_ready,
  input wire       i_strong_pullup_active,
  input wire       o_link_ready,
  input wire       o_scl_o,
  input wire       o_sda_o,
  input wire       o_sck,
  input wire       o_ss_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  reg       fetch_q;
  reg       op_rd_q;
  reg       sck_q;
  reg [7:0] op_q;
  reg [7:0] cnt_q;
  // first read after an accepted start is the opcode fetch; cnt_q saturates so idle gaps never trip the rate check
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fetch_q <= 1'b0;
      op_rd_q <= 1'b0;
      op_q    <= 8'h00;
      sck_q   <= 1'b0;
      cnt_q   <= 8'hFF;
    end else begin
      fetch_q <= (i_cmd_start & o_link_ready) | (fetch_q & ~o_mem_rd);
      op_rd_q <= o_mem_rd & fetch_q;
      if (o_mem_rd && fetch_q) begin
        op_q <= i_mem_rdata;
      end
      sck_q <= o_sck;
      cnt_q <= (o_sck != sck_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
    end
  end
  property p_link;
    o_busy |-> !o_link_ready;
  endproperty
  a_link: assert property (p_link) else $error("link ready while busy");
  property p_done_end;
    o_cmd_done || o_cmd_err |=> !o_busy && o_link_ready;
  endproperty
  a_done_end: assert property (p_done_end) else $error("link not reopened after command");
  property p_ss_low;
    op_rd_q && op_q == 8'h80 && i_strong_pullup_active |-> ##[1:2] !o_ss_n;
  endproperty
  a_ss_low: assert property (p_ss_low) else $error("select low command left select high");
  property p_ss_high;
    op_rd_q && op_q == 8'h01 && i_strong_pullup_active |-> ##[1:2] o_ss_n;
  endproperty
  a_ss_high: assert property (p_ss_high) else $error("select high command left select low");
  property p_ss_hold;
    $changed(o_ss_n) |-> op_rd_q && (op_q == 8'h80 || op_q == 8'h01);
  endproperty
  a_ss_hold: assert property (p_ss_hold) else $error("select moved outside select commands");
  property p_pullup;
    (!i_strong_pullup_active) [*4] ##0 (o_mem_rd && fetch_q) |-> ##[1:3] o_cmd_err;
  endproperty
  a_pullup: assert property (p_pullup) else $error("command ran without pullup");
  property p_wr_hold;
    o_mem_wr && !i_mem_wr_ready |=> o_mem_wr && $stable(o_mem_waddr) && $stable(o_mem_wdata);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("refused store not held");
  property p_bit_rate;
    o_busy && op_q == 8'hB0 && $changed(o_sck) |-> cnt_q >= 8'd37;
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("bit clock half period too short");
  property p_od;
    o_scl_o == 1'b0 && o_sda_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("bus line driven high");
endmodule

bind sqx_exec sqx_exec_checker u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_start(i_cmd_start), .o_busy(o_busy),
  .o_cmd_done(o_cmd_done), .o_cmd_err(o_cmd_err), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata),
  .o_mem_wr(o_mem_wr), .o_mem_waddr(o_mem_waddr), .o_mem_wdata(o_mem_wdata),
  .i_mem_wr_ready(i_mem_wr_ready), .i_strong_pullup_active(i_strong_pullup_active),
  .o_link_ready(o_link_ready), .o_scl_o(o_scl_o), .o_sda_o(o_sda_o), .o_sck(o_sck), .o_ss_n(o_ss_n)
);
`default_nettype wire

// ### tb/sqx_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module sqx_far_model (
  input  wire       i_clk,
  input  wire       i_stall,
  input  wire       i_rd,
  input  wire [8:0] i_raddr,
  output wire  [7:0] o_rdata,
  input  wire       i_wr,
  input  wire [8:0] i_waddr,
  input  wire [7:0] i_wdata,
  output wire       o_wr_ready,
  input  wire       i_scl_oe,
  input  wire       i_sda_oe,
  output wire       o_scl,
  output wire       o_sda,
  input  wire       i_sck,
  input  wire       i_mosi,
  input  wire       i_ss_n,
  output wire       o_miso
);
  logic [7:0]  mem [0:511];
  logic [15:0] ackv = 16'h0000;
  logic [7:0]  tmp;
  logic        s_oe = 1'b0;
  logic        miso_q = 1'b0;
  // cnt starts at 0 with s_oe low, so the released SDA line already presents bit 7 of the first byte
  integer      cnt = 0;
  integer      idx = 0;
  integer      rcnt = 0;
  logic        mosi_q [$];
  function automatic logic sbit(input integer i);
    sbit = i[0] ^ i[2] ^ i[3];
  endfunction
  assign o_wr_ready = !i_stall;
  // read data stands only while the strobe does
  assign o_rdata = i_rd ? mem[i_raddr] : 8'hFF;
  always @(posedge i_clk) begin
    if (i_wr && !i_stall) mem[i_waddr] <= i_wdata;
  end
  // both lines pulled up; this slave never stretches the clock
  assign o_scl = !i_scl_oe;
  assign o_sda = !(i_sda_oe || s_oe);
  always @(negedge o_scl) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    if (cnt == 0) idx = idx + 1;
    tmp = 8'hC5 ^ idx[7:0];
    s_oe = (cnt < 8) && !tmp[7 - cnt];
  end
  always @(posedge o_scl) if (cnt == 8 && idx >= 0) ackv[idx] = o_sda;
  always @(negedge i_ss_n) begin
    rcnt = 0;
    mosi_q.delete();
    miso_q = sbit(0);
  end
  always @(posedge i_sck) if (!i_ss_n) begin
    mosi_q.push_back(i_mosi);
    rcnt = rcnt + 1;
  end
  // data moves on the falling edge of sck and when select falls, away from the sampling edge
  always @(negedge i_sck) if (!i_ss_n) miso_q = sbit(rcnt);
  assign o_miso = i_ss_n ? !miso_q : miso_q;
endmodule
`default_nettype wire

// ### tb/seq_i2c_nack_read_spi_xfer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sqx_defs.vh"
module seq_i2c_nack_read_spi_xfer_bench;
  logic       i_clk, i_arst_n, i_cmd_start, i_strong_pullup_active, i_link_valid, stall, lr;
  logic [8:0] i_cmd_addr, o_next_addr, o_mem_raddr, o_mem_waddr, nxt;
  logic [7:0] i_mem_rdata, o_mem_wdata;
  logic       o_busy, o_cmd_done, o_cmd_err, o_mem_rd, o_mem_wr, i_mem_wr_ready, o_link_ready;
  logic       o_scl_o, o_scl_oe, i_scl, o_sda_o, o_sda_oe, i_sda, o_sck, o_mosi, i_miso, o_ss_n;
  integer     miscompares = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  sqx_exec DUT (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_start(i_cmd_start), .i_cmd_addr(i_cmd_addr),
    .o_busy(o_busy), .o_cmd_done(o_cmd_done), .o_cmd_err(o_cmd_err), .o_next_addr(o_next_addr),
    .o_mem_rd(o_mem_rd), .o_mem_raddr(o_mem_raddr), .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr),
    .o_mem_waddr(o_mem_waddr), .o_mem_wdata(o_mem_wdata), .i_mem_wr_ready(i_mem_wr_ready),
    .i_strong_pullup_active(i_strong_pullup_active), .i_link_valid(i_link_valid),
    .o_link_ready(o_link_ready), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .i_scl(i_scl),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_sda(i_sda), .o_sck(o_sck), .o_mosi(o_mosi),
    .i_miso(i_miso), .o_ss_n(o_ss_n)
  );
  sqx_far_model u_far (
    .i_clk(i_clk), .i_stall(stall), .i_rd(o_mem_rd), .i_raddr(o_mem_raddr), .o_rdata(i_mem_rdata),
    .i_wr(o_mem_wr), .i_waddr(o_mem_waddr), .i_wdata(o_mem_wdata), .o_wr_ready(i_mem_wr_ready),
    .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda),
    .i_sck(o_sck), .i_mosi(o_mosi), .i_ss_n(o_ss_n), .o_miso(i_miso)
  );
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  task end_of_test;
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one idle edge first, so a start never lands on the edge that reopens the link
  task run(input logic [8:0] a, input logic exp_err, input integer hold);
    integer n;
    logic d, e;
    n = 0;
    d = 0;
    e = 0;
    lr = 0;
    @(posedge i_clk);
    #1 stall = (hold > 0);
    i_cmd_addr = a;
    i_cmd_start = 1;
    @(posedge i_clk);
    #1 i_cmd_start = 0;
    i_link_valid = 1;
    while (!d && !e && n < 20000) begin
      @(posedge i_clk);
      #1 n = n + 1;
      if (n == hold) begin
        chk("busy_at_release", 1, o_busy);
        stall = 0;
      end
      lr = lr | o_link_ready;
      d = o_cmd_done;
      e = o_cmd_err;
    end
    nxt = o_next_addr;
    i_link_valid = 0;
    stall = 0;
    chk("completed", 1, d | e);
    chk("link_ready", 0, lr);
    chk("cmd_err", exp_err, e);
  endtask
  task spi(input logic [7:0] op, input logic [7:0] wl, input logic [7:0] rl, input integer hold);
    integer i, n, wbits, rbits, wb, rb;
    logic [7:0] v;
    wbits = (op == `SQX_OP_SPI_BIT) ? wl : wl * 8;
    rbits = (op == `SQX_OP_SPI_BIT) ? rl : rl * 8;
    wb = (wbits + 7) / 8;
    rb = (rbits + 7) / 8;
    u_far.mem[32] = op;
    u_far.mem[33] = wl;
    u_far.mem[34] = rl;
    for (i = 0; i < wb; i++) u_far.mem[35 + i] = 8'h96 + 8'(i) * 8'h1D;
    for (i = 0; i < rb; i++) u_far.mem[35 + wb + i] = `SQX_FILL;
    run(9'h000, 0, 0);
    run(9'h020, 0, hold);
    chk("next_addr", 9'(35 + wb + rb), nxt);
    chk("sck_rises", 9'(wbits + rbits), 9'(u_far.mosi_q.size()));
    for (i = 0; i < wbits; i++) begin
      v = 8'h96 + 8'(i / 8) * 8'h1D;
      chk("mosi_bit", 9'(v[7 - i % 8]), 9'(u_far.mosi_q[i]));
    end
    for (i = 0; i < rb; i++) begin
      v = 8'hFF;
      for (n = 0; n < 8 && 8 * i + n < rbits; n++) v = {v[6:0], u_far.sbit(wbits + 8 * i + n)};
      chk("read_byte", 9'(v), 9'(u_far.mem[35 + wb + i]));
    end
    run(9'h001, 0, 0);
  endtask
  task t_select;
    run(9'h000, 0, 0);
    chk("ss_n_low", 0, o_ss_n);
    chk("next_addr", 9'h001, nxt);
    run(9'h001, 0, 0);
    chk("ss_n_high", 1, o_ss_n);
  endtask
  task t_pullup;
    i_strong_pullup_active = 0;
    repeat (4) @(posedge i_clk);
    #1 run(9'h000, 1, 0);
    chk("ss_n_kept", 1, o_ss_n);
    i_strong_pullup_active = 1;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task t_i2c;
    integer k;
    for (k = 0; k < 11; k++) u_far.mem[18 + k] = `SQX_FILL;
    u_far.mem[16] = `SQX_OP_I2C_RDNAK;
    u_far.mem[17] = 8'h03;
    u_far.mem[24] = `SQX_OP_I2C_RDNAK;
    u_far.mem[25] = 8'h01;
    run(9'h010, 0, 0);
    chk("next_addr", 9'h015, nxt);
    run(9'h018, 0, 0);
    chk("next_addr", 9'h01B, nxt);
    for (k = 0; k < 3; k++) begin
      chk("i2c_byte", 9'(8'hC5 ^ 8'(k)), 9'(u_far.mem[18 + k]));
      chk("i2c_ack", 9'(k == 2), 9'(u_far.ackv[k]));
    end
    chk("i2c_byte", 9'h0C6, 9'(u_far.mem[26]));
    chk("i2c_ack", 1, u_far.ackv[3]);
  endtask
  task t_spi_byte;
    spi(`SQX_OP_SPI_BYTE, 8'd2, 8'd20, 3000);
  endtask
  task t_spi_skip;
    spi(`SQX_OP_SPI_BYTE, 8'd0, 8'd1, 0);
    spi(`SQX_OP_SPI_BYTE, 8'd1, 8'd0, 0);
    spi(`SQX_OP_SPI_BYTE, 8'd0, 8'd0, 0);
  endtask
  task t_spi_bit;
    spi(`SQX_OP_SPI_BIT, 8'd12, 8'd10, 0);
    spi(`SQX_OP_SPI_BIT, 8'd64, 8'd1, 0);
    spi(`SQX_OP_SPI_BIT, 8'd0, 8'd64, 0);
  endtask
  initial begin
    i_clk = 0;
    i_arst_n = 0;
    i_cmd_start = 0;
    i_cmd_addr = 9'h000;
    i_strong_pullup_active = 1;
    i_link_valid = 0;
    stall = 0;
    u_far.mem[0] = `SQX_OP_SS_LOW;
    u_far.mem[1] = `SQX_OP_SS_HIGH;
    repeat (10) @(posedge i_clk);
    #1 i_arst_n = 1;
    repeat (5) @(posedge i_clk);
    #1 t_select;
    t_pullup;
    t_i2c;
    t_spi_byte;
    t_spi_skip;
    t_spi_bit;
    end_of_test;
  end
endmodule
`default_nettype wire
